// ==== src/capture_pkg.sv ====
// package: modes, positions and sizing constants for the capture controller
package capture_pkg;
    // write modes
    typedef enum logic [1:0] {
        MODE_CONTINUOUS,
        MODE_QUALIFIED,
        MODE_SEGMENTED
    } write_mode_t;
    // post-trigger fraction selects
    typedef enum logic [1:0] {
        POS_POST,   // 12% after trigger
        POS_CENTER, // 50% after trigger
        POS_PRE     // 88% after trigger
    } trig_pos_t;
    // post-fill fractions in eighths of the depth
    localparam int POST_EIGHTHS_12 = 1;
    localparam int POST_EIGHTHS_50 = 4;
    localparam int POST_EIGHTHS_88 = 7;
    localparam int EIGHTH_SHIFT    = 3;
    localparam int DEFAULT_DEPTH   = 64;
    localparam int DEFAULT_WIDTH   = 8;
    localparam int DEFAULT_SEGS    = 4;
    localparam int FIFO_DEPTH      = 16;
    // one probed sample with its trigger and qualifier inputs
    typedef struct packed {
        logic [DEFAULT_WIDTH-1:0] data;
        logic                     trig;
        logic                     qual;
    } probe_t;
    // one acquisition memory write
    typedef struct packed {
        logic [15:0]              addr;
        logic [DEFAULT_WIDTH-1:0] data;
        logic                     is_trigger;
    } mem_write_t;
endpackage

// ==== src/capture_control.sv ====
// file: sample fifo and acquisition write/trigger controller
`timescale 1ns/100ps
`default_nettype none
// What this block does
// (R1) three write modes: continuous, qualified, segmented, chosen before run
// (R2) continuous mode fills whole buffer before evaluating any trigger
// (R3) continuous mode: no readback before first fill; early stop dumps nothing
// (R4) segmented and qualified modes evaluate triggers from first written sample
// (R5) trigger before pre-trigger count is met triggers at once
// (R6) post position stores 12% of depth after trigger, eight at 64
// (R7) qualifier don't-care stores every sample
// (R8) qualified mode with always-store triggers on first matching sample
// (R9) next segment starts at post-fill end or next trigger, whichever first
// (R10) post-trigger fraction selectable: 12%, 50% or 88% of depth; segmented mode always uses half a segment
// (R11) after post-fill: stop writes, flag complete, hold until read or restart

// sample fifo: parameterised width and depth, valid/ready on both sides
module sample_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             sys_rst,
    // fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    initial begin
        if (DEPTH < 2 || (1 << AW) != DEPTH) begin
            $error("sample_fifo depth must be a power of two >= 2");
        end
    end
    logic [WIDTH-1:0] store [DEPTH];
    logic [AW:0]      wptr;
    logic [AW:0]      rptr;
    logic [AW:0]      next_wptr;
    logic [AW:0]      next_rptr;
    logic             push;
    logic             pop;

    // full and empty from pointer compare
    always_comb begin
        in_ready  = (wptr - rptr) != (AW+1)'(DEPTH);
        out_valid = wptr != rptr;
        out_data  = store[rptr[AW-1:0]];
        push      = in_valid && in_ready;
        pop       = out_valid && out_ready;
        next_wptr = push ? wptr + 1'b1 : wptr;
        next_rptr = pop ? rptr + 1'b1 : rptr;
    end

    // pointers and storage
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wptr <= '0;
            rptr <= '0;
        end else begin
            wptr <= next_wptr;
            rptr <= next_rptr;
        end
        if (push) begin
            store[wptr[AW-1:0]] <= in_data;
        end
    end
endmodule

// acquisition write and trigger controller
module capture_control #(
    parameter int WIDTH = capture_pkg::DEFAULT_WIDTH,
    parameter int DEPTH = capture_pkg::DEFAULT_DEPTH,
    parameter int SEGS  = capture_pkg::DEFAULT_SEGS
) (
    // clock and reset
    input  wire logic                        clk,
    input  wire logic                        sys_rst,
    // probed signals from the design
    input  wire logic [WIDTH-1:0]            probe_data,
    input  wire logic                        basic_trigger_condition_one,
    input  wire logic                        qual_match,
    // run control from the debug host
    input  wire capture_pkg::write_mode_t    write_mode,
    input  wire capture_pkg::trig_pos_t      trig_pos,
    input  wire logic                        qual_dont_care,
    input  wire logic                        run_start,
    input  wire logic                        stop_request,
    input  wire logic                        readback_done,
    // acquisition memory write port
    output logic                             mem_we,
    output logic [$clog2(DEPTH)-1:0]         mem_addr,
    output logic [WIDTH-1:0]                 mem_data,
    output logic                             mem_is_trigger,
    // status
    output logic                             probe_ready,
    output logic                             acquiring,
    output logic                             triggered,
    output logic                             capture_done,
    output logic                             readback_allowed,
    output logic [$clog2(SEGS+1)-1:0]        segment
);
    localparam int AW = $clog2(DEPTH);
    localparam int SW = $clog2(SEGS+1);
    localparam int SEG_DEPTH = DEPTH / SEGS;
    initial begin
        if (DEPTH < 8 || (1 << AW) != DEPTH || SEGS < 1 ||
                DEPTH % SEGS != 0) begin
            $error("capture_control depth or segment count unsupported");
        end
    end

    typedef enum logic [2:0] {
        S_IDLE,
        S_PREFILL,
        S_ARMED,
        S_POSTFILL,
        S_DONE
    } state_t;

    // two-flop synchronisers for the probe pins
    localparam int PW = WIDTH + 2;
    logic [PW-1:0] sync_a;
    logic [PW-1:0] sync_b;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sync_a <= '0;
            sync_b <= '0;
        end else begin
            sync_a <= {probe_data, basic_trigger_condition_one, qual_match};
            sync_b <= sync_a;
        end
    end

    // probe samples buffered before the controller
    logic          fifo_valid;
    logic          fifo_ready;
    logic [PW-1:0] fifo_data;
    sample_fifo #(
        .WIDTH (PW),
        .DEPTH (capture_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .in_valid  (1'b1),
        .in_ready  (probe_ready),
        .in_data   (sync_b),
        .out_valid (fifo_valid),
        .out_ready (fifo_ready),
        .out_data  (fifo_data)
    );

    state_t             state;
    state_t             next_state;
    logic [AW:0]        fill;
    logic [AW:0]        next_fill;
    logic [AW:0]        post;
    logic [AW:0]        next_post;
    logic [AW-1:0]      wr;
    logic [AW-1:0]      next_wr;
    logic [SW-1:0]      next_segment;
    logic               filled_once;
    logic               next_filled_once;
    logic               next_triggered;
    logic [AW:0]        post_target;
    logic [AW:0]        cap;
    logic               take;
    logic               store_it;
    logic               trig_hit;
    logic               segmented;
    logic               trig_mark;
    logic [AW-1:0]      wr_step;

    // post-fill target from selected fraction
    always_comb begin
        unique case (trig_pos)  // [R10]
            capture_pkg::POS_POST:   post_target = (AW+1)'(
                (DEPTH >> capture_pkg::EIGHTH_SHIFT) *
                capture_pkg::POST_EIGHTHS_12);  // [R6]
            capture_pkg::POS_CENTER: post_target = (AW+1)'(
                (DEPTH >> capture_pkg::EIGHTH_SHIFT) *
                capture_pkg::POST_EIGHTHS_50);
            default:                 post_target = (AW+1)'(
                (DEPTH >> capture_pkg::EIGHTH_SHIFT) *
                capture_pkg::POST_EIGHTHS_88);
        endcase
        segmented = write_mode == capture_pkg::MODE_SEGMENTED;
        if (segmented) begin
            post_target = (AW+1)'(SEG_DEPTH) >> 1;
            if (post_target == '0) begin
                post_target = (AW+1)'(1);
            end
        end
    end

    // next-state logic for the capture sequence
    always_comb begin
        next_state       = state;
        next_fill        = fill;
        next_post        = post;
        next_wr          = wr;
        next_segment     = segment;
        next_filled_once = filled_once;
        next_triggered   = triggered;
        cap      = segmented ? (AW+1)'(SEG_DEPTH) : (AW+1)'(DEPTH);
        wr_step  = segmented ? (wr & ~AW'(SEG_DEPTH - 1)) |
            ((wr + 1'b1) & AW'(SEG_DEPTH - 1)) : wr + 1'b1;  // [R9]
        take     = 1'b0;
        store_it = 1'b0;
        trig_hit = 1'b0;
        trig_mark = 1'b0;
        if (state == S_PREFILL || state == S_ARMED ||
                state == S_POSTFILL) begin
            take = fifo_valid;
            // qualifier gates storage in qualified mode unless don't care
            store_it = take && (write_mode != capture_pkg::MODE_QUALIFIED ||
                qual_dont_care || fifo_data[0]);  // [R7]
        end
        trig_hit = store_it && fifo_data[1];
        unique case (state)
            S_IDLE, S_DONE: begin
                // a finished buffer stays frozen until read back or restarted
                if (run_start) begin  // [R1] [R11]
                    next_state       = segmented ||
                        write_mode == capture_pkg::MODE_QUALIFIED ?
                        S_ARMED : S_PREFILL;  // [R4]
                    next_fill        = '0;
                    next_post        = '0;
                    next_wr          = '0;
                    next_segment     = '0;
                    next_filled_once = 1'b0;
                    next_triggered   = 1'b0;
                end else if (state == S_DONE && readback_done) begin
                    next_state = S_IDLE;  // [R11]
                end
            end
            S_PREFILL: begin
                // triggers ignored until the whole buffer is written
                if (store_it) begin  // [R2]
                    next_wr   = wr_step;
                    next_fill = fill + 1'b1;
                    if (fill + 1'b1 == cap) begin
                        next_state       = S_ARMED;
                        next_filled_once = 1'b1;  // [R3]
                    end
                end
            end
            S_ARMED: begin
                if (store_it) begin
                    next_wr = wr_step;
                    if (fill != cap) begin
                        next_fill = fill + 1'b1;
                    end
                    // trigger wins over any pre-trigger shortfall
                    if (trig_hit) begin  // [R5] [R8]
                        trig_mark      = 1'b1;
                        next_triggered = 1'b1;
                        next_post      = '0;
                        next_state     = S_POSTFILL;
                    end
                end
            end
            S_POSTFILL: begin
                if (store_it) begin
                    next_wr   = wr_step;
                    next_post = post + 1'b1;
                    if (segmented && trig_hit &&
                            segment + 1'b1 != SW'(SEGS)) begin
                        // next segment trigger preempts post-fill
                        trig_mark      = 1'b1;  // [R9]
                        next_segment   = segment + 1'b1;
                        next_wr = AW'((segment + 1'b1) * SEG_DEPTH);
                        next_post = '0;
                    end else if (post + 1'b1 == post_target) begin
                        if (segmented && segment + 1'b1 != SW'(SEGS)) begin
                            next_segment = segment + 1'b1;  // [R9]
                            next_wr = AW'((segment + 1'b1) * SEG_DEPTH);
                            next_state = S_ARMED;
                            next_fill  = '0;
                        end else begin
                            next_state       = S_DONE;  // [R6] [R11]
                            next_filled_once = 1'b1;
                        end
                    end
                end
            end
            default: next_state = S_IDLE;
        endcase
        // early stop during prefill keeps the buffer unoffered
        if (stop_request && state != S_IDLE && state != S_DONE) begin
            next_state = (filled_once || state != S_PREFILL) ?
                S_DONE : S_IDLE;  // [R3]
        end
    end

    // fifo drains only while acquiring; write port from flops
    assign fifo_ready = take;
    always_comb begin
        acquiring        = state == S_PREFILL || state == S_ARMED ||
            state == S_POSTFILL;
        capture_done     = state == S_DONE;
        readback_allowed = capture_done &&
            (filled_once || write_mode != capture_pkg::MODE_CONTINUOUS);
    end

    // control registers
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state       <= S_IDLE;
            fill        <= '0;
            post        <= '0;
            wr          <= '0;
            segment     <= '0;
            filled_once <= 1'b0;
            triggered   <= 1'b0;
            mem_we      <= 1'b0;
            mem_addr    <= '0;
            mem_data    <= '0;
            mem_is_trigger <= 1'b0;
        end else begin
            state       <= next_state;
            fill        <= next_fill;
            post        <= next_post;
            wr          <= next_wr;
            segment     <= next_segment;
            filled_once <= next_filled_once;
            triggered   <= next_triggered;
            mem_we      <= store_it;  // [R11]
            mem_addr    <= wr;
            mem_data    <= fifo_data[PW-1:2];
            mem_is_trigger <= trig_mark;  // [R5]
        end
    end
endmodule
`default_nettype wire

// ==== bench/capture_control_props.sv ====
// checker: port timing relations of the capture controller
`timescale 1ns/100ps
`default_nettype none
module capture_control_props #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 64,
    parameter int SEGS  = 4
) (
    // clock and reset
    input wire logic                      clk,
    input wire logic                      sys_rst,
    // probes and run control
    input wire logic                      basic_trigger_condition_one,
    input wire logic                      qual_match,
    input wire capture_pkg::write_mode_t  write_mode,
    input wire capture_pkg::trig_pos_t    trig_pos,
    input wire logic                      qual_dont_care,
    input wire logic                      run_start,
    input wire logic                      stop_request,
    input wire logic                      readback_done,
    // outputs under watch
    input wire logic                      mem_we,
    input wire logic                      acquiring,
    input wire logic                      triggered,
    input wire logic                      capture_done,
    input wire logic                      readback_allowed,
    input wire logic [$clog2(SEGS+1)-1:0] segment,
    input wire logic [$clog2(DEPTH)-1:0]  mem_addr,
    input wire logic                      mem_is_trigger
);
    localparam int POST12 = (DEPTH * capture_pkg::POST_EIGHTHS_12)
                            >> capture_pkg::EIGHTH_SHIFT;
    int   wr_cnt, post_cnt, next_wr_cnt, next_post_cnt;
    logic cont;
    // writes since the run began, and writes after the trigger
    always_comb begin
        cont          = write_mode == capture_pkg::MODE_CONTINUOUS;
        next_wr_cnt   = run_start ? 0 : wr_cnt + int'(mem_we);
        next_post_cnt = run_start ? 0 : post_cnt + int'(mem_we & triggered);
    end
    always_ff @(posedge clk) begin
        wr_cnt   <= sys_rst ? 0 : next_wr_cnt;
        post_cnt <= sys_rst ? 0 : next_post_cnt;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    a_prefill_no_trigger: assert property (
        cont && acquiring && wr_cnt < DEPTH - 1 |-> !triggered)
        else $error("trigger seen before the buffer filled");
    a_readback_gate: assert property (
        cont && readback_allowed |-> wr_cnt >= DEPTH)
        else $error("readback offered before one full fill");
    a_stop_prefill: assert property (
        cont && acquiring && stop_request && wr_cnt < DEPTH - 4
        |-> ##[1:4] (!acquiring && !capture_done))
        else $error("early stop did not return to idle");
    a_qual_blocks: assert property (
        (write_mode == capture_pkg::MODE_QUALIFIED && !qual_dont_care
         && !qual_match) [*6] |-> !mem_we)
        else $error("write while qualifier low");
    a_qual_trig_now: assert property (
        (write_mode == capture_pkg::MODE_QUALIFIED && qual_dont_care
         && acquiring && basic_trigger_condition_one) [*8] |-> triggered)
        else $error("qualified mode did not trigger at once");
    a_post_fill_count: assert property (
        $rose(capture_done) && write_mode != capture_pkg::MODE_SEGMENTED
        && trig_pos == capture_pkg::POS_POST && triggered
        |-> post_cnt inside {[POST12 - 1:POST12 + 1]})
        else $error("post fill count wrong");
    a_done_no_write: assert property (
        capture_done && $past(capture_done) |-> !mem_we)
        else $error("write after capture complete");
    a_done_holds: assert property (
        capture_done && !run_start && !readback_done |=> capture_done)
        else $error("complete flag dropped without read or restart");
    a_segment_step: assert property (
        write_mode == capture_pkg::MODE_SEGMENTED && !run_start
        && !readback_done |=> segment == $past(segment)
        || segment == $past(segment) + 1'b1)
        else $error("segment index jumped");
    a_trig_marked: assert property (
        mem_is_trigger |-> mem_we && triggered)
        else $error("trigger mark outside a write");
    a_addr_step: assert property (
        write_mode != capture_pkg::MODE_SEGMENTED && mem_we
        && $past(mem_we) |-> mem_addr == $past(mem_addr) + 1'b1)
        else $error("write address skipped");
endmodule
bind capture_control capture_control_props #(
    .WIDTH(WIDTH), .DEPTH(DEPTH), .SEGS(SEGS)
) props_u (
    .clk(clk), .sys_rst(sys_rst),
    .basic_trigger_condition_one(basic_trigger_condition_one),
    .qual_match(qual_match), .write_mode(write_mode),
    .trig_pos(trig_pos), .qual_dont_care(qual_dont_care),
    .run_start(run_start), .stop_request(stop_request),
    .readback_done(readback_done), .mem_we(mem_we),
    .acquiring(acquiring), .triggered(triggered),
    .capture_done(capture_done), .readback_allowed(readback_allowed),
    .segment(segment), .mem_addr(mem_addr),
    .mem_is_trigger(mem_is_trigger)
);
`default_nettype wire

// ==== bench/host_model.sv ====
// partner: debug host that counts stored samples and reads them back
`timescale 1ns/100ps
`default_nettype none
module host_model (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       sys_rst,
    // capture side
    input  wire logic       run_start,
    input  wire logic       mem_we,
    input  wire logic       readback_allowed,
    input  wire logic [7:0] read_wait,
    // readback handshake and tally
    output logic            readback_done,
    output int              write_total
);
    int   wait_cnt;
    logic served;
    // read only once the buffer is offered, after read_wait cycles
    always_ff @(posedge clk) begin
        readback_done <= 1'b0;
        if (sys_rst || run_start) begin
            write_total <= 0;
            wait_cnt    <= 0;
            served      <= 1'b0;
        end else begin
            write_total <= write_total + int'(mem_we);
            if (readback_allowed && !served) begin
                wait_cnt <= wait_cnt + 1;
                if (wait_cnt == int'(read_wait)) begin
                    readback_done <= 1'b1;
                    served        <= 1'b1;
                end
            end
        end
    end
endmodule
`default_nettype wire

// ==== bench/tb.sv ====
// testbench: capture runs in every write mode with count checks
`timescale 1ns/100ps
`default_nettype none
module tb;
    localparam int DEPTH = 64;
    localparam int SEGS  = 4;
    logic clk = 1'b0, sys_rst = 1'b1, trig = 1'b0, qual = 1'b0;
    logic dont_care = 1'b0, run_start = 1'b0, stop_request = 1'b0;
    logic [7:0] probe_data = 8'h00, read_wait = 8'h02;
    capture_pkg::write_mode_t mode = capture_pkg::MODE_CONTINUOUS;
    capture_pkg::trig_pos_t   pos  = capture_pkg::POS_POST;
    logic readback_done, mem_we, acquiring, triggered, capture_done;
    logic readback_allowed, probe_ready;
    logic [2:0] segment;
    int   writes, bad_count = 0, total_checks = 0;
    // clock and a moving probe pattern
    always #5 clk = ~clk;
    always @(negedge clk) probe_data <= probe_data + 8'h01;
    capture_control #(.WIDTH(8), .DEPTH(DEPTH), .SEGS(SEGS)) dut_u (
        .clk(clk), .sys_rst(sys_rst), .probe_data(probe_data),
        .basic_trigger_condition_one(trig), .qual_match(qual),
        .write_mode(mode), .trig_pos(pos), .qual_dont_care(dont_care),
        .run_start(run_start), .stop_request(stop_request),
        .readback_done(readback_done), .mem_we(mem_we), .mem_addr(),
        .mem_data(), .mem_is_trigger(), .probe_ready(probe_ready),
        .acquiring(acquiring), .triggered(triggered),
        .capture_done(capture_done), .readback_allowed(readback_allowed),
        .segment(segment));
    host_model host_u (
        .clk(clk), .sys_rst(sys_rst), .run_start(run_start),
        .mem_we(mem_we), .readback_allowed(readback_allowed),
        .read_wait(read_wait), .readback_done(readback_done),
        .write_total(writes));
    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    task automatic start_run(input capture_pkg::write_mode_t m,
                             input capture_pkg::trig_pos_t p,
                             input logic dc);
        @(negedge clk);
        mode = m;
        pos = p;
        dont_care = dc;
        @(negedge clk);
        run_start = 1'b1;
        @(negedge clk);
        run_start = 1'b0;
    endtask
    task automatic wait_done(input int n);
        for (int i = 0; i <= n; i++) begin
            @(negedge clk);
            if (capture_done === 1'b1) begin
                @(negedge clk);  // last write reaches the host tally
                break;
            end
            if (i == n) begin
                bad_count++;
                stop_test();
            end
        end
    endtask
    task automatic test_cont();
        trig = 1'b1;
        read_wait = 8'h28;
        start_run(capture_pkg::MODE_CONTINUOUS, capture_pkg::POS_POST, 1'b0);
        wait_done(400);
        check("cont writes", DEPTH + 1 + DEPTH / 8, writes);
        check("cont readback", 1, readback_allowed);
        repeat (20) @(negedge clk);
        check("held writes", DEPTH + 1 + DEPTH / 8, writes);
        check("held done", 1, capture_done);
        check("fifo held full", 0, probe_ready);
        repeat (40) @(negedge clk);
        $display("test cont finished");
    endtask
    task automatic test_stop();
        start_run(capture_pkg::MODE_CONTINUOUS, capture_pkg::POS_POST, 1'b0);
        repeat (20) @(negedge clk);
        stop_request = 1'b1;
        @(negedge clk);
        stop_request = 1'b0;
        repeat (5) @(negedge clk);
        check("stop acquiring", 0, acquiring);
        check("stop done", 0, capture_done);
        check("stop readback", 0, readback_allowed);
        $display("test stop finished");
    endtask
    task automatic test_qual();
        capture_pkg::trig_pos_t p[3];
        int e[3];
        p = '{capture_pkg::POS_POST, capture_pkg::POS_CENTER,
              capture_pkg::POS_PRE};
        e = '{capture_pkg::POST_EIGHTHS_12, capture_pkg::POST_EIGHTHS_50,
              capture_pkg::POST_EIGHTHS_88};
        read_wait = 8'h02;
        for (int i = 0; i < 3; i++) begin
            start_run(capture_pkg::MODE_QUALIFIED, p[i], 1'b1);
            wait_done(200);
            check("qual writes", 1 + ((DEPTH * e[i]) >> 3), writes);
            check("qual trig", 1, triggered);
        end
        trig = 1'b0;
        $display("test qual finished");
    endtask
    task automatic test_block();
        start_run(capture_pkg::MODE_QUALIFIED, capture_pkg::POS_POST, 1'b0);
        repeat (30) @(negedge clk);
        check("blocked writes", 0, writes);
        trig = 1'b1;
        qual = 1'b1;
        wait_done(200);
        check("gated writes", 1 + DEPTH / 8, writes);
        qual = 1'b0;
        $display("test block finished");
    endtask
    task automatic test_seg();
        start_run(capture_pkg::MODE_SEGMENTED, capture_pkg::POS_POST, 1'b0);
        wait_done(600);
        check("seg writes", SEGS + DEPTH / SEGS / 2, writes);
        check("seg index", SEGS - 1, segment);
        $display("test seg finished");
    endtask
    initial begin
        repeat (10) @(negedge clk);
        sys_rst = 1'b0;
        test_cont();
        test_stop();
        test_qual();
        test_block();
        test_seg();
        stop_test();
    end
endmodule
`default_nettype wire
